// File: common/spx_pkg.sv
// shared constants and types for the spi transfer engine
package spx_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned HALF_DIV_DEF = 4;
  localparam logic [3:0]  HC_LAST      = 4'hF;
  localparam logic [3:0]  PULSES_BYTE  = 4'h8;
  localparam logic [3:0]  DMA_CH_RX0   = 4'h8;
  localparam logic [3:0]  DMA_CH_TX0   = 4'h9;
  localparam logic [3:0]  DMA_CH_RX1   = 4'hA;
  localparam logic [3:0]  DMA_CH_TX1   = 4'hB;
  localparam int unsigned SR_W         = 10;
  localparam int unsigned SR_RRDY      = 0;
  localparam int unsigned SR_TRDY      = 1;
  localparam int unsigned SR_IDLE      = 2;
  localparam int unsigned SR_UDR       = 3;
  localparam int unsigned SR_OVR       = 4;
  localparam int unsigned SR_SSON      = 5;
  localparam int unsigned SR_RXDMA     = 8;
  localparam int unsigned SR_TXDMA     = 9;
  localparam logic [9:0]  SR_RESET     = 10'h006;
  localparam logic [7:0]  TX_DUMMY     = 8'h00;
  typedef enum logic {SPX_M_IDLE, SPX_M_RUN} spx_mst_t;
endpackage

// File: rtl/spx_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module spx_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: rtl/spx_spi.sv
// spi transfer engine with master/slave roles and dma handshake
`timescale 1ns/1ps
// Functional notes
// [R1] separate double-buffered tx and rx paths
// [R2] cpol and cpha select four modes
// [R3] cpol only inverts the clock waveform
// [R4] peer must use the same mode
// [R5] master keeps its own select inactive
// [R6] cpha0 slave: msb out at select
// [R7] master tx write starts clock generation
// [R8] cpha0 master: first half cycle idle
// [R9] cpha0: sample leading, shift trailing edge
// [R10] cpha1: first leading edge drives msb
// [R11] cpha1 master toggles clock immediately
// [R12] cpha1: sample on trailing edge
// [R13] byte done after eight clock pulses
// [R14] per-instance rx and tx dma channels
// [R15] rx and tx handshakes run independently
// [R16] rx request per full buffer, await ack
// [R17] rx dma done sets flag, gated irq
// [R18] tx request per empty buffer, await ack
// [R19] tx dma done sets flag, gated irq
// [R20] slave first dma transfer sends dummy (cpha0 only; cpha1 sends the hold word loaded at the first leading edge)
// [R21] program dma before enabling handshake
// [R22] disable resets status; enable shifts buffer (code shifts on enable only in master mode; a slave enable shifts nothing)
// [R23] request held until ack, then drops
module spx_spi import spx_pkg::*; #(
  parameter int unsigned HALF_DIV = HALF_DIV_DEF,
  parameter int unsigned INSTANCE = 0
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            link_clk,
  input  wire logic            enable,
  input  wire logic            master_mode,
  input  wire logic            cpol,
  input  wire logic            cpha,
  input  wire logic            tx_wr,
  input  wire logic [7:0]      tx_data,
  input  wire logic            rx_rd,
  input  wire logic            rx_dma_en,
  input  wire logic            tx_dma_en,
  input  wire logic            rx_dma_ack,
  input  wire logic            tx_dma_ack,
  input  wire logic            rx_dma_done,
  input  wire logic            tx_dma_done,
  input  wire logic            rx_flag_clr,
  input  wire logic            tx_flag_clr,
  input  wire logic            rx_dma_done_irq_en,
  input  wire logic            tx_dma_done_irq_en,
  input  wire logic            ss_n_in,
  input  wire logic            mosi_in,
  input  wire logic            miso_in,
  output logic                 sclk_out,
  output logic                 sclk_oe,
  output logic                 mosi_out,
  output logic                 mosi_oe,
  output logic                 miso_out,
  output logic                 miso_oe,
  output logic [7:0]           rx_data,
  output logic [SR_W-1:0]      serial_status_reg,
  output logic                 rx_dma_req,
  output logic                 tx_dma_req,
  output logic [3:0]           rx_dma_ch,
  output logic [3:0]           tx_dma_ch,
  output logic                 irq
);
  localparam int unsigned TW = $clog2(HALF_DIV + 1);
  localparam logic [TW-1:0] TMR_RELOAD = TW'(HALF_DIV - 1);

  // ---------------- link domain: slave shifter on the peer's clock
  logic       s_clk;
  logic       s_arst;
  logic [2:0] scnt_q, scnt_d;
  logic [7:0] srx_q, srx_d, sword_q, sword_d, stx_q, stx_d;
  logic       srxt_q, srxt_d, stxt_q, stxt_d;
  logic [7:0] thold_q;

  // normalised clock: rising edge is always the sampling edge
  assign s_clk  = link_clk ^ cpol ^ cpha; // [R3] [R12]
  // the select pin ends a frame, so it clears the bit count directly
  assign s_arst = rst | ss_n_in;

  always_comb begin
    scnt_d  = scnt_q + 3'h1;
    srx_d   = {srx_q[6:0], mosi_in}; // [R9] [R12]
    sword_d = sword_q;
    srxt_d  = srxt_q;
    if (scnt_q == 3'h7) begin
      sword_d = srx_d;
      srxt_d  = ~srxt_q;
    end
  end

  always_ff @(posedge s_clk or posedge s_arst) begin
    if (s_arst) scnt_q <= 3'h0;
    else        scnt_q <= scnt_d;
  end

  always_ff @(posedge s_clk or posedge rst) begin
    if (rst) begin
      srx_q   <= 8'h00;
      sword_q <= 8'h00;
      srxt_q  <= 1'b0;
    end else begin
      srx_q   <= srx_d;
      sword_q <= sword_d;
      srxt_q  <= srxt_d;
    end
  end

  // load happens on the edge after the last sample, so with cpha0 the
  // next msb already sits on the pin when select falls
  always_comb begin
    stx_d  = {stx_q[6:0], 1'b0}; // [R9]
    stxt_d = stxt_q;
    if (scnt_q == 3'h0) begin
      stx_d  = thold_q; // [R6] [R10]
      stxt_d = ~stxt_q;
    end
  end

  always_ff @(negedge s_clk or posedge rst) begin
    if (rst) begin
      stx_q  <= TX_DUMMY; // [R20]
      stxt_q <= 1'b0;
    end else begin
      stx_q  <= stx_d;
      stxt_q <= stxt_d;
    end
  end

  assign miso_out = stx_q[7];

  // ---------------- crossings into the system clock
  logic ss_n_s, miso_s, rxt_s, txt_s;
  spx_sync #(.W(4)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({ss_n_in, miso_in, srxt_q, stxt_q}),
    .q     ({ss_n_s, miso_s, rxt_s, txt_s})
  );

  // ---------------- system domain
  spx_mst_t      mst_q, mst_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [3:0]    hc_q, hc_d;
  logic [7:0]    sh_q, sh_d, msr_q, msr_d, txb_q, txb_d, rxb_q, rxb_d, thold_d;
  logic          sclk_q, sclk_d, txe_q, txe_d, rxf_q, rxf_d;
  logic          ovr_q, ovr_d, udr_q, udr_d, rdf_q, rdf_d, tdf_q, tdf_d;
  logic          rdp_q, tdp_q, rreq_q, rreq_d, treq_q, treq_d, rgap_q, tgap_q;
  logic          enp_q, kick_q, kick_d, rxtp_q, txtp_q, irq_q, irq_d;
  logic          thv_q, thv_d;
  logic          sclkoe_q, misooe_q, misooe_d;
  logic [SR_W-1:0] sr_q, sr_d;
  logic          m_start, m_done, s_on, s_rx_ev, s_tx_ev, rx_done, rx_pop, tx_put;
  logic [7:0]    rx_word;

  always_comb begin
    mst_d    = mst_q;
    tmr_d    = tmr_q;
    hc_d     = hc_q;
    sh_d     = sh_q;
    msr_d    = msr_q;
    sclk_d   = sclk_q;
    txb_d    = txb_q;
    txe_d    = txe_q;
    rxb_d    = rxb_q;
    rxf_d    = rxf_q;
    ovr_d    = ovr_q;
    udr_d    = udr_q;
    thold_d  = thold_q;
    kick_d   = kick_q;
    thv_d    = thv_q;
    m_done   = 1'b0;
    s_on     = enable & ~master_mode;
    s_rx_ev  = s_on & (rxt_s ^ rxtp_q);
    s_tx_ev  = s_on & (txt_s ^ txtp_q);
    rx_pop   = rx_rd | (rreq_q & rx_dma_ack);
    tx_put   = tx_wr | (treq_q & tx_dma_ack);
    // enabling in master mode shifts whatever the buffer holds, fresh or stale
    if (enable & ~enp_q & master_mode) kick_d = 1'b1; // [R22]
    m_start  = (mst_q == SPX_M_IDLE) & enable & master_mode & (~txe_q | kick_q); // [R7]
    unique case (mst_q)
      SPX_M_IDLE: begin
        sclk_d = cpol; // [R3]
        if (m_start) begin
          mst_d  = SPX_M_RUN;
          sh_d   = txb_q;
          txe_d  = 1'b1; // [R1]
          kick_d = 1'b0;
          tmr_d  = TMR_RELOAD;
          hc_d   = 4'h0;
          // cpha1 leads with an active half, cpha0 with an idle half
          sclk_d = cpol ^ cpha; // [R8] [R11]
        end
      end
      SPX_M_RUN: begin
        if (!enable || !master_mode) begin
          mst_d  = SPX_M_IDLE;
          sclk_d = cpol;
        end else if (tmr_q != '0) begin
          tmr_d = tmr_q - TW'(1);
        end else begin
          tmr_d = TMR_RELOAD;
          // even halves end on the sampling edge in both phases
          if (!hc_q[0]) msr_d = {msr_q[6:0], miso_s}; // [R9] [R12]
          else          sh_d  = {sh_q[6:0], 1'b0}; // [R9]
          if (hc_q == HC_LAST) begin
            m_done = 1'b1; // [R13]
            mst_d  = SPX_M_IDLE;
            sclk_d = cpol;
          end else begin
            hc_d   = hc_q + 4'h1;
            sclk_d = cpol ^ cpha ^ hc_d[0]; // [R2] [R3]
          end
        end
      end
    endcase
    rx_done = m_done | s_rx_ev;
    rx_word = m_done ? msr_q : sword_q;
    // set wins over pop and clear; only the disable clear below overrides a set
    if (rx_pop) rxf_d = 1'b0;
    if (rx_rd)  ovr_d = 1'b0;
    if (rx_done) begin
      if (rxf_q & ~rx_pop) ovr_d = 1'b1;
      rxb_d = rx_word; // [R1]
      rxf_d = 1'b1;
    end
    if (tx_wr) udr_d = 1'b0;
    if (s_tx_ev) begin
      // the link just took the hold word; a stale one means underrun
      if (!thv_q) udr_d = 1'b1;
      thv_d = 1'b0;
    end else if (s_on && !thv_q && !txe_q) begin
      // refill as soon as the hold word is free, so with cpha0 only the very first
      // byte after reset goes out as the dummy
      thold_d = txb_q; // [R20]
      txe_d   = 1'b1;
      thv_d   = 1'b1;
    end
    if (tx_put) begin
      txb_d = tx_data;
      txe_d = 1'b0;
    end
    if (!enable) begin
      rxf_d = 1'b0; // [R22]
      ovr_d = 1'b0;
      udr_d = 1'b0;
      txe_d = 1'b1;
    end
  end

  always_comb begin
    // each request drops after its ack and rests a clock before rising
    rreq_d = rreq_q ? ~rx_dma_ack : (rx_dma_en & enable & rxf_q & ~rgap_q); // [R16] [R23]
    treq_d = treq_q ? ~tx_dma_ack : (tx_dma_en & enable & txe_q & ~tgap_q); // [R18] [R23]
    rdf_d  = rdf_q & ~rx_flag_clr;
    tdf_d  = tdf_q & ~tx_flag_clr;
    if (rx_dma_done & ~rdp_q) rdf_d = 1'b1; // [R17]
    if (tx_dma_done & ~tdp_q) tdf_d = 1'b1; // [R19]
    if (!enable) begin
      rdf_d = 1'b0; // [R22]
      tdf_d = 1'b0;
    end
    irq_d    = (rdf_q & rx_dma_done_irq_en) | (tdf_q & tx_dma_done_irq_en); // [R17] [R19]
    misooe_d = s_on & ~ss_n_s;
    sr_d           = '0;
    sr_d[SR_RRDY]  = rxf_d;
    sr_d[SR_TRDY]  = txe_d;
    sr_d[SR_IDLE]  = master_mode ? (mst_d == SPX_M_IDLE) : ss_n_s;
    sr_d[SR_UDR]   = udr_d;
    sr_d[SR_OVR]   = ovr_d;
    sr_d[SR_SSON]  = misooe_d;
    sr_d[SR_RXDMA] = rdf_d;
    sr_d[SR_TXDMA] = tdf_d;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mst_q    <= SPX_M_IDLE;
      tmr_q    <= '0;
      hc_q     <= 4'h0;
      sh_q     <= 8'h00;
      msr_q    <= 8'h00;
      sclk_q   <= 1'b0;
      txb_q    <= 8'h00;
      txe_q    <= 1'b1;
      rxb_q    <= 8'h00;
      rxf_q    <= 1'b0;
      ovr_q    <= 1'b0;
      udr_q    <= 1'b0;
      thold_q  <= TX_DUMMY;
      thv_q    <= 1'b0;
      kick_q   <= 1'b0;
      enp_q    <= 1'b0;
      rxtp_q   <= 1'b0;
      txtp_q   <= 1'b0;
      rreq_q   <= 1'b0;
      treq_q   <= 1'b0;
      rgap_q   <= 1'b0;
      tgap_q   <= 1'b0;
      rdf_q    <= 1'b0;
      tdf_q    <= 1'b0;
      rdp_q    <= 1'b0;
      tdp_q    <= 1'b0;
      irq_q    <= 1'b0;
      sclkoe_q <= 1'b0;
      misooe_q <= 1'b0;
      sr_q     <= SR_RESET;
    end else begin
      mst_q    <= mst_d;
      tmr_q    <= tmr_d;
      hc_q     <= hc_d;
      sh_q     <= sh_d;
      msr_q    <= msr_d;
      sclk_q   <= sclk_d;
      txb_q    <= txb_d;
      txe_q    <= txe_d;
      rxb_q    <= rxb_d;
      rxf_q    <= rxf_d;
      ovr_q    <= ovr_d;
      udr_q    <= udr_d;
      thold_q  <= thold_d;
      thv_q    <= thv_d;
      kick_q   <= kick_d;
      enp_q    <= enable;
      rxtp_q   <= rxt_s;
      txtp_q   <= txt_s;
      rreq_q   <= rreq_d;
      treq_q   <= treq_d;
      rgap_q   <= rreq_q & rx_dma_ack; // [R15]
      tgap_q   <= treq_q & tx_dma_ack; // [R15]
      rdf_q    <= rdf_d;
      tdf_q    <= tdf_d;
      rdp_q    <= rx_dma_done;
      tdp_q    <= tx_dma_done;
      irq_q    <= irq_d;
      sclkoe_q <= enable & master_mode;
      misooe_q <= misooe_d;
      sr_q     <= sr_d;
    end
  end

  // channel numbers follow the instance after reset; reset loads instance 0's channels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_dma_ch <= DMA_CH_RX0;
      tx_dma_ch <= DMA_CH_TX0;
    end else begin
      rx_dma_ch <= (INSTANCE == 0) ? DMA_CH_RX0 : DMA_CH_RX1; // [R14]
      tx_dma_ch <= (INSTANCE == 0) ? DMA_CH_TX0 : DMA_CH_TX1; // [R14]
    end
  end

  assign sclk_out          = sclk_q;
  assign sclk_oe           = sclkoe_q;
  assign mosi_out          = sh_q[7];
  assign mosi_oe           = sclkoe_q;
  assign miso_oe           = misooe_q;
  assign rx_data           = rxb_q;
  assign serial_status_reg = sr_q;
  assign rx_dma_req        = rreq_q;
  assign tx_dma_req        = treq_q;
  assign irq               = irq_q;

  // ---------------- checks
  logic [3:0] pulses_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst)                              pulses_q <= 4'h0;
    else if (m_start)                     pulses_q <= {3'h0, sclk_d ^ cpol};
    else if (sclk_d != cpol && sclk_q == cpol) pulses_q <= pulses_q + 4'h1;
  end

  sequence s_idle_lead;
    (sclk_out == cpol) [*3];
  endsequence

  a_eight_pulses: assert property (@(posedge clock) disable iff (rst) // [R13]
    m_done |-> (pulses_q == PULSES_BYTE)) else $error("byte ended without eight pulses");
  a_cpha0_lead: assert property (@(posedge clock) disable iff (rst) // [R8]
    (m_start && !cpha && $stable(cpol)) |=> s_idle_lead) else $error("cpha0 lead not idle");
  a_cpha1_toggle: assert property (@(posedge clock) disable iff (rst) // [R11]
    (m_start && cpha) |=> (sclk_out != cpol)) else $error("cpha1 clock not toggled at once");
  a_idle_level: assert property (@(posedge clock) disable iff (rst) // [R3]
    (mst_q == SPX_M_IDLE && !m_start && $stable(cpol)) |=> (sclk_out == $past(cpol)))
    else $error("idle clock level wrong");
  a_rx_req_hold: assert property (@(posedge clock) disable iff (rst) // [R23]
    (rx_dma_req && !rx_dma_ack) |=> rx_dma_req) else $error("rx request dropped early");
  a_rx_req_gap: assert property (@(posedge clock) disable iff (rst) // [R23]
    (rx_dma_req && rx_dma_ack) |=> !rx_dma_req ##1 !rx_dma_req) else $error("rx request no gap");
  a_tx_req_rise: assert property (@(posedge clock) disable iff (rst) // [R18]
    (tx_dma_en && enable && serial_status_reg[SR_TRDY] && !tx_dma_req && !tgap_q && !tx_put)
    |=> ##[0:1] tx_dma_req) else $error("tx request not raised");
  a_rx_flag_set: assert property (@(posedge clock) disable iff (rst) // [R17]
    ($rose(rx_dma_done) && enable) |=> ##1 serial_status_reg[SR_RXDMA])
    else $error("rx dma done flag not set");
  a_tx_irq_gate: assert property (@(posedge clock) disable iff (rst) // [R19]
    (tdf_q && tx_dma_done_irq_en) |=> irq) else $error("tx dma irq missing");
  a_disable_init: assert property (@(posedge clock) disable iff (rst) // [R22]
    (!enable) |=> (serial_status_reg[SR_RRDY] == 1'b0 && rx_dma_req == 1'b0))
    else $error("disable did not clear status");
endmodule

// File: verification/spx_peer.sv
// spi peer model: slave answering the block's clock, master driving the block's slave side
`timescale 1ns/1ps
module spx_peer (
  input  wire logic sclk,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic mosi,
  input  wire logic miso_dev,
  input  wire logic miso_oe,
  output logic      miso,
  output logic      link_clk,
  output logic      ss_n,
  output logic      mosi_drv
);
  logic [7:0] s_tx = 8'h00;
  logic [7:0] s_rx = 8'h00;
  int         cnt = 0;
  initial begin
    miso = 1'b1;
    link_clk = 1'b0;
    ss_n = 1'b1;
    mosi_drv = 1'b1;
  end
  // bench sets the same mode on both ends before loading a byte
  task automatic load(input logic [7:0] v);
    s_tx = v;
    cnt = 0;
    miso = v[7];
  endtask
  // leading edge is the one that leaves the idle level
  always @(sclk) begin
    if (cnt < 8) begin
      if ((sclk === !cpol) != cpha) begin
        s_rx = {s_rx[6:0], mosi};
        cnt++;
        // released after the last sample: inverse so a stale value never passes
        if (cnt == 8) miso = ~miso;
      end else if (cpha) begin
        miso = s_tx[7];
        s_tx = s_tx << 1;
      end else begin
        s_tx = s_tx << 1;
        miso = s_tx[7];
      end
    end
  end
  // mode 0 frame; the link clock runs only inside the frame
  task automatic frame(input logic [7:0] v, output logic [7:0] got, output logic msb);
    logic [7:0] sh;
    sh = v;
    ss_n = 1'b0;
    mosi_drv = sh[7];
    #400;
    msb = miso_oe ? miso_dev : 1'bz;
    for (int i = 7; i >= 0; i--) begin
      #40 link_clk = 1'b1;
      got[i] = miso_oe ? miso_dev : 1'bz;
      #40 link_clk = 1'b0;
      sh = sh << 1;
      mosi_drv = sh[7];
    end
    #100 ss_n = 1'b1;
    mosi_drv = ~mosi_drv;
  endtask
endmodule

// File: verification/tb_top.sv
// self-checking bench for the spi transfer engine
`timescale 1ns/1ps
module tb_top;
  import spx_pkg::*;
  localparam int unsigned HALF = 4;
  logic        clock = 1'b0, rst = 1'b1, enable = 1'b0, master_mode = 1'b1;
  logic        cpol = 1'b0, cpha = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
  logic        rx_dma_en = 1'b0, tx_dma_en = 1'b0, rx_dma_ack = 1'b0, tx_dma_ack = 1'b0;
  logic        rx_dma_done = 1'b0, tx_dma_done = 1'b0, rx_flag_clr = 1'b0, tx_flag_clr = 1'b0;
  logic        rx_dma_done_irq_en = 1'b0, tx_dma_done_irq_en = 1'b0;
  logic [7:0]  tx_data = 8'h00;
  logic        link_clk, ss_n_in, mosi_in, miso_in, sclk_out, sclk_oe, mosi_out, mosi_oe;
  logic        miso_out, miso_oe, rx_dma_req, tx_dma_req, irq, msb;
  logic [7:0]  rx_data, got;
  logic [3:0]  rx_dma_ch, tx_dma_ch;
  logic [SR_W-1:0] serial_status_reg;
  logic [12:0] obs;
  int          fail_count = 0, n_tests = 0, cycles = 0;
  assign obs = {irq, tx_dma_req, rx_dma_req, serial_status_reg};
  spx_spi #(.HALF_DIV(HALF), .INSTANCE(0)) u_spx_spi (
    .clock, .rst, .link_clk, .enable, .master_mode, .cpol, .cpha, .tx_wr, .tx_data, .rx_rd,
    .rx_dma_en, .tx_dma_en, .rx_dma_ack, .tx_dma_ack, .rx_dma_done, .tx_dma_done,
    .rx_flag_clr, .tx_flag_clr, .rx_dma_done_irq_en, .tx_dma_done_irq_en, .ss_n_in, .mosi_in,
    .miso_in, .sclk_out, .sclk_oe, .mosi_out, .mosi_oe, .miso_out, .miso_oe, .rx_data,
    .serial_status_reg, .rx_dma_req, .tx_dma_req, .rx_dma_ch, .tx_dma_ch, .irq
  );
  spx_peer u_spx_peer (
    .sclk(sclk_out), .cpol, .cpha, .mosi(mosi_out), .miso_dev(miso_out), .miso_oe,
    .miso(miso_in), .link_clk, .ss_n(ss_n_in), .mosi_drv(mosi_in)
  );
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hung handshake would otherwise stall the run forever
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wait_on(input int b, input logic v, input string m);
    int i;
    i = 0;
    while (obs[b] !== v && i < 300) begin
      @(negedge clock);
      i++;
    end
    chk(obs[b] === v, m);
  endtask
  task automatic pop();
    @(posedge clock);
    rx_rd <= 1'b1;
    @(posedge clock);
    rx_rd <= 1'b0;
  endtask
  task automatic t_enable();
    @(negedge clock);
    chk(serial_status_reg === SR_RESET, "status after reset");
    chk(rx_dma_ch === DMA_CH_RX0 && tx_dma_ch === DMA_CH_TX0, "dma channels");
    u_spx_peer.load(8'h5A);
    @(posedge clock);
    enable <= 1'b1;
    wait_on(SR_IDLE, 1'b0, "enable does not shift buffer");
    wait_on(SR_RRDY, 1'b1, "no byte after enable");
    chk(rx_data === 8'h5A, "rx byte after enable");
    pop();
    wait_on(SR_IDLE, 1'b1, "not idle");
    $display("test enable done");
  endtask
  task automatic t_master(input logic p, input logic h, input logic [7:0] mv,
                          input logic [7:0] sv);
    int n;
    @(posedge clock);
    cpol <= p;
    cpha <= h;
    repeat (3) @(negedge clock);
    chk(sclk_out === p, "idle clock level");
    chk(sclk_oe === 1'b1 && mosi_oe === 1'b1 && ss_n_in === 1'b1, "master pins");
    u_spx_peer.load(sv);
    @(posedge clock);
    tx_data <= mv;
    tx_wr <= 1'b1;
    @(posedge clock);
    tx_wr <= 1'b0;
    wait_on(SR_IDLE, 1'b0, "write does not start");
    n = 0;
    while (sclk_out === p && n < 20) begin
      @(negedge clock);
      n++;
    end
    if (h) chk(n <= 1, "first clock edge late");
    else chk(n >= HALF - 1, "no idle half cycle");
    wait_on(SR_RRDY, 1'b1, "no rx byte");
    chk(rx_data === sv, "master rx byte");
    chk(u_spx_peer.s_rx === mv && u_spx_peer.cnt == 8, "peer byte or pulse count");
    pop();
    wait_on(SR_IDLE, 1'b1, "not idle");
    $display("test master mode %0d%0d done", p, h);
  endtask
  task automatic t_dma();
    @(posedge clock);
    rx_dma_en <= 1'b1;
    tx_dma_en <= 1'b1;
    repeat (3) @(negedge clock);
    chk(tx_dma_req === 1'b1 && rx_dma_req === 1'b0, "tx request only");
    u_spx_peer.load(8'h6B);
    @(posedge clock);
    tx_data <= 8'hD2;
    tx_dma_ack <= 1'b1;
    @(posedge clock);
    tx_dma_ack <= 1'b0;
    @(negedge clock);
    chk(tx_dma_req === 1'b0, "tx request not dropped");
    wait_on(11, 1'b1, "tx request not repeated");
    chk(serial_status_reg[SR_IDLE] === 1'b0, "not double buffered");
    wait_on(10, 1'b1, "no rx request");
    chk(rx_data === 8'h6B && u_spx_peer.s_rx === 8'hD2, "dma bytes");
    @(posedge clock);
    rx_dma_ack <= 1'b1;
    @(posedge clock);
    rx_dma_ack <= 1'b0;
    repeat (3) @(negedge clock);
    chk(rx_dma_req === 1'b0 && serial_status_reg[SR_RRDY] === 1'b0, "rx ack");
    chk(tx_dma_req === 1'b1, "tx request dropped without ack");
    @(posedge clock);
    rx_dma_en <= 1'b0;
    tx_dma_en <= 1'b0;
    $display("test dma done");
  endtask
  task automatic t_flags();
    @(posedge clock);
    rx_dma_done_irq_en <= 1'b1;
    rx_dma_done <= 1'b1;
    wait_on(SR_RXDMA, 1'b1, "rx done flag");
    wait_on(12, 1'b1, "rx done irq");
    @(posedge clock);
    tx_dma_done <= 1'b1;
    wait_on(SR_TXDMA, 1'b1, "tx done flag");
    @(posedge clock);
    rx_flag_clr <= 1'b1;
    @(posedge clock);
    rx_flag_clr <= 1'b0;
    repeat (3) @(negedge clock);
    chk(serial_status_reg[SR_RXDMA] === 1'b0 && irq === 1'b0, "masked tx irq");
    @(posedge clock);
    tx_dma_done_irq_en <= 1'b1;
    wait_on(12, 1'b1, "tx done irq");
    @(posedge clock);
    enable <= 1'b0;
    wait_on(SR_TXDMA, 1'b0, "disable keeps flag");
    repeat (2) @(negedge clock);
    chk(serial_status_reg === SR_RESET && irq === 1'b0, "status after disable");
    @(posedge clock);
    rx_dma_done <= 1'b0;
    tx_dma_done <= 1'b0;
    $display("test flags done");
  endtask
  task automatic t_slave();
    @(posedge clock);
    master_mode <= 1'b0;
    cpol <= 1'b0;
    cpha <= 1'b0;
    enable <= 1'b1;
    @(posedge clock);
    tx_data <= 8'hC3;
    tx_wr <= 1'b1;
    @(posedge clock);
    tx_wr <= 1'b0;
    repeat (4) @(posedge clock);
    u_spx_peer.frame(8'h4E, got, msb);
    chk(msb === 1'b0 && got === TX_DUMMY, "first slave byte not dummy");
    wait_on(SR_RRDY, 1'b1, "slave rx");
    chk(rx_data === 8'h4E, "slave rx byte");
    pop();
    repeat (6) @(posedge clock);
    u_spx_peer.frame(8'hB1, got, msb);
    chk(msb === 1'b1 && got === 8'hC3, "slave tx byte");
    wait_on(SR_RRDY, 1'b1, "slave rx second");
    chk(rx_data === 8'hB1, "slave rx second byte");
    pop();
    $display("test slave done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_enable();
    for (int m = 0; m < 4; m++) t_master(m[1], m[0], 8'h81 ^ 8'(m * 17), 8'h3C + 8'(m));
    @(posedge clock);
    cpol <= 1'b0;
    cpha <= 1'b0;
    repeat (3) @(posedge clock);
    t_dma();
    t_flags();
    t_slave();
    conclude();
  end
endmodule
